// File: core/smi_i2c_master.sv
`timescale 1ns/1ps
// Behaviour
// - sole bus master; no arbitration logic, any number of slaves share lines.
// - every bus timing is derived from the system clock input.
// - fixed divide-by-sixteen prescaler is the basic timing step.
// - bit time is four quarters of sixteen times divisor plus four clocks.
// - slaves may stretch clock; master waits for clock line really high.
// - start is data pulled low while clock stays high.
// - start only at the beginning of a transaction.
// - stop is data released high while clock is high.
// - data changes only while clock low, except start and stop.
// - write is start, two or three acked bytes, then stop.
// - 24-bit data word shifted left, first byte MSB goes first.
// - bit zero of first byte low means write, high means read.
// - select input chooses two-byte or three-byte write.
// - read is start, acked address, one received byte, nack, stop.
// - received byte is shifted into the third byte field.
// - completion of every transaction raises an interrupt pulse.
// - status bit tells whether all expected acknowledges arrived.
// - software may disable sequencer and drive both lines directly.
module smi_i2c_master (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // control
  input wire logic hw_enable_i,
  input wire logic start_i,
  input wire logic three_byte_write_select_i,
  input wire logic [7:0] bit_rate_divisor_i,
  // transmit data
  input wire logic [7:0] tx_byte_first_i,
  input wire logic [7:0] tx_byte_second_i,
  input wire logic [7:0] tx_rx_byte_third_i,
  // software line control
  input wire logic sw_scl_i,
  input wire logic sw_sda_i,
  // status
  output logic busy_o,
  output logic done_o,
  output logic slave_ack_ok_status_o,
  output logic [23:0] data_o,
  output logic scl_level_o,
  output logic sda_level_o,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_o,
  output logic sda_o,
  output logic sda_oe_o
);

  smi_pkg::smi_state_e state_q;
  logic [1:0] qtr_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_idx_q;
  logic [3:0] pre_q;
  logic [7:0] div_cnt_q;
  logic [23:0] data_q;
  logic [23:0] sh_q;
  logic w3_q;
  logic samp_q;
  logic ack_ok_q;
  logic done_q;
  logic scl_low_q;
  logic sda_low_q;
  logic scl_meta_q;
  logic scl_sync_q;
  logic sda_meta_q;
  logic sda_sync_q;

  logic busy;
  logic stall;
  logic in_tail;
  logic qtick;
  logic rd;
  logic rx_byte;
  logic last_byte;
  logic tx_bit;
  logic ack_slot;
  logic [1:0] last_idx;

  assign busy = (state_q != smi_pkg::SMI_IDLE);
  assign rd = data_q[smi_pkg::SMI_DIR_POS];
  assign rx_byte = rd && (byte_idx_q == smi_pkg::SMI_IDX_SECOND);
  assign ack_slot = (bit_cnt_q == smi_pkg::SMI_ACK_SLOT);
  // read is address plus one data byte; write is two or three bytes
  assign last_idx = (!rd && w3_q) ? smi_pkg::SMI_IDX_THIRD
                                  : smi_pkg::SMI_IDX_SECOND;
  assign last_byte = (byte_idx_q == last_idx);
  // master releases data on ack slots and while receiving; nack after read data
  assign tx_bit = (ack_slot || rx_byte) ? 1'b1 : sh_q[23];

  // pins pass two flip-flops before any logic looks at them
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
    end else begin
      scl_meta_q <= scl_i;
      scl_sync_q <= scl_meta_q;
      sda_meta_q <= sda_i;
      sda_sync_q <= sda_meta_q;
    end
  end

  // a released clock line that still reads low is a slave stretching it;
  // the sync delay adds two clocks to every rising edge, a small trade for safety
  assign stall = busy && !scl_low_q && !scl_sync_q;

  // prescaler and divisor: quarter bit = 16 * div + 4 clocks
  assign in_tail = (div_cnt_q >= bit_rate_divisor_i);
  assign qtick = busy && !stall && in_tail && (pre_q == smi_pkg::SMI_TAIL_LAST);

  always_ff @(posedge clk_i) begin
    if (!nrst_i || !busy) begin
      pre_q <= smi_pkg::SMI_PRE_RST;
      div_cnt_q <= smi_pkg::SMI_DIV_CNT_RST;
    end else if (!stall) begin
      if (qtick) begin
        pre_q <= smi_pkg::SMI_PRE_RST;
        div_cnt_q <= smi_pkg::SMI_DIV_CNT_RST;
      end else if (!in_tail && pre_q == smi_pkg::SMI_PRE_LAST) begin
        pre_q <= smi_pkg::SMI_PRE_RST;
        div_cnt_q <= div_cnt_q + 8'h01;
      end else begin
        pre_q <= pre_q + 4'h1;
      end
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= smi_pkg::SMI_IDLE;
      qtr_q <= smi_pkg::SMI_Q_SET;
      bit_cnt_q <= smi_pkg::SMI_BIT_FIRST;
      byte_idx_q <= smi_pkg::SMI_IDX_FIRST;
    end else begin
      case (state_q)
        smi_pkg::SMI_IDLE: begin
          if (start_i && hw_enable_i) begin
            state_q <= smi_pkg::SMI_START;
            qtr_q <= smi_pkg::SMI_Q_SET;
            bit_cnt_q <= smi_pkg::SMI_BIT_FIRST;
            byte_idx_q <= smi_pkg::SMI_IDX_FIRST;
          end
        end
        smi_pkg::SMI_START: begin
          if (!hw_enable_i) begin
            state_q <= smi_pkg::SMI_IDLE;
          end else if (qtick) begin
            qtr_q <= qtr_q + 2'h1;
            if (qtr_q == smi_pkg::SMI_Q_FALL) begin
              state_q <= smi_pkg::SMI_BITS;
            end
          end
        end
        smi_pkg::SMI_BITS: begin
          if (!hw_enable_i) begin
            state_q <= smi_pkg::SMI_IDLE;
          end else if (qtick) begin
            qtr_q <= qtr_q + 2'h1;
            if (qtr_q == smi_pkg::SMI_Q_FALL) begin
              if (!ack_slot) begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end else if (last_byte || (!rx_byte && samp_q)) begin
                // a missing acknowledge ends the transaction early with stop
                state_q <= smi_pkg::SMI_STOP;
              end else begin
                bit_cnt_q <= smi_pkg::SMI_BIT_FIRST;
                byte_idx_q <= byte_idx_q + 2'h1;
              end
            end
          end
        end
        smi_pkg::SMI_STOP: begin
          if (!hw_enable_i) begin
            state_q <= smi_pkg::SMI_IDLE;
          end else if (qtick) begin
            qtr_q <= qtr_q + 2'h1;
            if (qtr_q == smi_pkg::SMI_Q_FALL) begin
              state_q <= smi_pkg::SMI_IDLE;
            end
          end
        end
        default: begin
          state_q <= smi_pkg::SMI_IDLE;
        end
      endcase
    end
  end

  // data word and transmit shifter
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      data_q <= smi_pkg::SMI_DATA_RST;
      sh_q <= smi_pkg::SMI_DATA_RST;
      w3_q <= 1'b0;
    end else if (!busy && start_i && hw_enable_i) begin
      data_q <= {tx_byte_first_i, tx_byte_second_i, tx_rx_byte_third_i};
      sh_q <= {tx_byte_first_i, tx_byte_second_i, tx_rx_byte_third_i};
      w3_q <= three_byte_write_select_i;
    end else if (state_q == smi_pkg::SMI_BITS && qtick && qtr_q == smi_pkg::SMI_Q_FALL
                 && !ack_slot) begin
      sh_q <= {sh_q[22:0], 1'b0};
      if (rx_byte) begin
        data_q[7:0] <= {data_q[6:0], samp_q};
      end
    end
  end

  // sample the data line at the end of the first of the two clock high quarters
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      samp_q <= 1'b1;
    end else if (state_q == smi_pkg::SMI_BITS && qtick && qtr_q == smi_pkg::SMI_Q_SAMPLE) begin
      samp_q <= sda_sync_q;
    end
  end

  // acknowledge status: any missing acknowledge on a sent byte marks failure
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_ok_q <= 1'b0;
    end else if (!busy && start_i && hw_enable_i) begin
      ack_ok_q <= 1'b1;
    end else if (state_q == smi_pkg::SMI_BITS && qtick && qtr_q == smi_pkg::SMI_Q_FALL
                 && ack_slot && !rx_byte && samp_q) begin
      ack_ok_q <= 1'b0;
    end else if (busy && !hw_enable_i) begin
      ack_ok_q <= 1'b0;
    end
  end

  // completion pulse towards the host interrupt logic
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == smi_pkg::SMI_STOP) && qtick
                && (qtr_q == smi_pkg::SMI_Q_FALL);
    end
  end

  // line drivers; with the sequencer off, software owns both lines
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (!busy || !hw_enable_i) begin
      scl_low_q <= !hw_enable_i && !sw_scl_i;
      sda_low_q <= !hw_enable_i && !sw_sda_i;
    end else if (qtick) begin
      case (state_q)
        smi_pkg::SMI_START: begin
          if (qtr_q == smi_pkg::SMI_Q_SET) begin
            sda_low_q <= 1'b1;
          end else if (qtr_q == smi_pkg::SMI_Q_RISE) begin
            scl_low_q <= 1'b1;
          end
        end
        smi_pkg::SMI_BITS: begin
          if (qtr_q == smi_pkg::SMI_Q_SET) begin
            sda_low_q <= !tx_bit;
          end else if (qtr_q == smi_pkg::SMI_Q_RISE) begin
            scl_low_q <= 1'b0;
          end else if (qtr_q == smi_pkg::SMI_Q_FALL) begin
            scl_low_q <= 1'b1;
          end
        end
        smi_pkg::SMI_STOP: begin
          if (qtr_q == smi_pkg::SMI_Q_SET) begin
            sda_low_q <= 1'b1;
          end else if (qtr_q == smi_pkg::SMI_Q_RISE) begin
            scl_low_q <= 1'b0;
          end else if (qtr_q == smi_pkg::SMI_Q_SAMPLE) begin
            sda_low_q <= 1'b0;
          end
        end
        default: begin
          scl_low_q <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: only ever pull low, no contention check since no other master
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_low_q;
  assign sda_oe_o = sda_low_q;

  assign busy_o = busy;
  assign done_o = done_q;
  assign slave_ack_ok_status_o = ack_ok_q;
  assign data_o = data_q;
  assign scl_level_o = scl_sync_q;
  assign sda_level_o = sda_sync_q;

endmodule

// File: shared/smi_pkg.sv
package smi_pkg;

  // data and divisor widths
  localparam int SMI_DIV_W = 8;
  localparam int SMI_DATA_W = 24;

  // position of the direction bit (bit 0 of the first byte) in the data word
  localparam int SMI_DIR_POS = 16;

  // fixed prescaler: sixteen clocks per prescaler tick
  localparam logic [3:0] SMI_PRE_LAST = 4'hF;

  // four extra clocks close every quarter bit: quarter = 16 * div + 4
  localparam logic [3:0] SMI_TAIL_LAST = 4'h3;

  // bit counter value of the acknowledge slot (ninth clock)
  localparam logic [3:0] SMI_ACK_SLOT = 4'h8;
  localparam logic [3:0] SMI_BIT_FIRST = 4'h0;

  // byte index: 0 address, 1 second byte, 2 third byte
  localparam logic [1:0] SMI_IDX_FIRST = 2'h0;
  localparam logic [1:0] SMI_IDX_SECOND = 2'h1;
  localparam logic [1:0] SMI_IDX_THIRD = 2'h2;

  // quarter phases of one bit cell
  localparam logic [1:0] SMI_Q_SET = 2'h0;
  localparam logic [1:0] SMI_Q_RISE = 2'h1;
  localparam logic [1:0] SMI_Q_SAMPLE = 2'h2;
  localparam logic [1:0] SMI_Q_FALL = 2'h3;

  // reset values
  localparam logic [23:0] SMI_DATA_RST = 24'h00_0000;
  localparam logic [3:0] SMI_PRE_RST = 4'h0;
  localparam logic [7:0] SMI_DIV_CNT_RST = 8'h00;

  typedef enum logic [3:0] {
    SMI_IDLE  = 4'h1,
    SMI_START = 4'h2,
    SMI_BITS  = 4'h4,
    SMI_STOP  = 4'h8
  } smi_state_e;

endpackage

// File: testbench/smi_i2c_master_properties.sv
`timescale 1ns/1ps
module smi_i2c_master_properties (
  // clock, reset, control
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic hw_enable_i,
  input wire logic start_i,
  input wire logic sw_scl_i,
  input wire logic sw_sda_i,
  // status and pins
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic scl_level_o,
  input wire logic scl_o,
  input wire logic sda_o,
  input wire logic scl_oe_o,
  input wire logic sda_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_take;
    start_i && !busy_o && hw_enable_i;
  endsequence
  // both lines idle for at least a short quarter before the start edge
  sequence s_lead;
    (!scl_oe_o && !sda_oe_o) [*4];
  endsequence
  property p_take;
    s_take |=> busy_o ##0 s_lead;
  endproperty
  a_take: assert property (p_take) else $error("start not taken cleanly");
  property p_hold;
    busy_o && hw_enable_i |=> busy_o || done_o;
  endproperty
  a_hold: assert property (p_hold) else $error("busy lost without done");
  property p_pulse;
    done_o |=> !done_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  property p_stretch;
    $rose(scl_oe_o) && busy_o && $past(hw_enable_i) |-> $past(scl_level_o);
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock pulled before high");
  property p_stop;
    $fell(sda_oe_o) && !scl_oe_o && hw_enable_i && $past(hw_enable_i) |-> scl_level_o;
  endproperty
  a_stop: assert property (p_stop) else $error("data released while clock low");
  property p_sw;
    $past(nrst_i) && !$past(hw_enable_i) |->
      scl_oe_o == !$past(sw_scl_i) && sda_oe_o == !$past(sw_sda_i);
  endproperty
  a_sw: assert property (p_sw) else $error("lines not under software");
  property p_od;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
endmodule
bind smi_i2c_master smi_i2c_master_properties i_smi_i2c_master_properties (
  .clk_i, .nrst_i, .hw_enable_i, .start_i, .sw_scl_i, .sw_sda_i, .busy_o, .done_o,
  .scl_level_o, .scl_o, .sda_o, .scl_oe_o, .sda_oe_o);

// File: testbench/smi_slave_model.sv
`timescale 1ns/1ps
module smi_slave_model (
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // behaviour
  input wire logic ack_en_i,
  input wire logic stretch_i,
  input wire logic [7:0] rd_byte_i,
  // pulls and record
  output logic scl_low_o = 0,
  output logic sda_low_o = 0,
  output logic [23:0] got_o = 24'h00_0000
);
  int cnt = 0;
  logic rd = 0;
  logic adr = 0;
  logic [7:0] sh = 8'h00;
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      // the clock fall that closes the start is not a data bit
      cnt = -1;
      adr = 1;
      rd = 0;
    end
  end
  always @(posedge scl_i) sh = {sh[6:0], sda_i};
  // data moves only on falling clock
  always @(negedge scl_i) begin
    cnt = cnt + 1;
    if (cnt == 8) got_o = {got_o[15:0], sh};
    if (cnt == 9) begin
      cnt = 0;
      rd = adr & sh[1];
      adr = 0;
    end
    sda_low_o = (cnt == 8) ? (ack_en_i & !rd) : (rd & (cnt < 8) & !rd_byte_i[7 - cnt]);
    if (stretch_i) begin
      scl_low_o = 1;
      // longer than half a bit so the master really sees the line held low
      #400;
      scl_low_o = 0;
    end
  end
endmodule

// File: testbench/smi_i2c_master_tb.sv
`timescale 1ns/1ps
module smi_i2c_master_tb;
  localparam int QTR = 16 * 1 + 4;
  logic clk_i = 0, nrst_i = 0, hw_enable_i = 1, start_i = 0, three_byte_write_select_i = 0;
  logic [7:0] bit_rate_divisor_i = 8'h01, tx_byte_first_i = 8'h00;
  logic [7:0] tx_byte_second_i = 8'h00, tx_rx_byte_third_i = 8'h00, rd_byte = 8'h00;
  logic sw_scl_i = 1, sw_sda_i = 1, ack_en = 1, stretch = 1;
  logic busy_o, done_o, slave_ack_ok_status_o, scl_level_o, sda_level_o;
  logic scl_oe_o, sda_oe_o, scl_low, sda_low;
  logic [23:0] data_o, got;
  int checks = 0, error_cnt = 0, cyc = 0, per = 0;
  wire scl_i = !scl_oe_o & !scl_low;
  wire sda_i = !sda_oe_o & !sda_low;
  initial forever #2.5 clk_i = !clk_i;
  smi_i2c_master i_smi_i2c_master (.clk_i, .nrst_i, .hw_enable_i, .start_i,
    .three_byte_write_select_i, .bit_rate_divisor_i, .tx_byte_first_i, .tx_byte_second_i,
    .tx_rx_byte_third_i, .sw_scl_i, .sw_sda_i, .busy_o, .done_o, .slave_ack_ok_status_o,
    .data_o, .scl_level_o, .sda_level_o, .scl_i, .sda_i, .scl_o(), .scl_oe_o, .sda_o(),
    .sda_oe_o);
  smi_slave_model i_smi_slave_model (.scl_i, .sda_i, .ack_en_i(ack_en), .stretch_i(stretch),
    .rd_byte_i(rd_byte), .scl_low_o(scl_low), .sda_low_o(sda_low), .got_o(got));
  // span of the last full bit cell
  always @(posedge clk_i) begin
    cyc <= $rose(scl_oe_o) ? 1 : cyc + 1;
    if ($rose(scl_oe_o)) per <= cyc;
  end
  task automatic end_sim();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                     input logic w3);
    int n;
    tx_byte_first_i <= a;
    tx_byte_second_i <= b;
    tx_rx_byte_third_i <= c;
    three_byte_write_select_i <= w3;
    start_i <= 1;
    @(posedge clk_i);
    start_i <= 0;
    for (n = 0; n < 20000 && done_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 20000) begin
      error_cnt++;
      end_sim();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1;
    @(posedge clk_i);
    chk({20'h0, busy_o, done_o, scl_oe_o, sda_oe_o}, 24'h00_0000);
    run(8'hA4, 8'h5C, 8'h3B, 1);
    chk(got, 24'hA4_5C3B);
    chk(data_o, 24'hA4_5C3B);
    chk({23'h0, slave_ack_ok_status_o}, 24'h00_0001);
    stretch <= 0;
    run(8'h42, 8'h81, 8'hFF, 0);
    chk(got, 24'h3B_4281);
    chk({23'h0, per >= 4 * QTR && per <= 4 * QTR + 4}, 24'h00_0001);
    rd_byte <= 8'h96;
    run(8'hA5, 8'h11, 8'h22, 1);
    chk(got, 24'h81_A596);
    chk(data_o, 24'hA5_1196);
    chk({23'h0, slave_ack_ok_status_o}, 24'h00_0001);
    ack_en <= 0;
    run(8'h50, 8'h01, 8'h02, 1);
    chk(got, 24'hA5_9650);
    chk({23'h0, slave_ack_ok_status_o}, 24'h00_0000);
    hw_enable_i <= 0;
    sw_scl_i <= 0;
    start_i <= 1;
    repeat (5) @(posedge clk_i);
    chk({19'h0, busy_o, scl_oe_o, sda_oe_o, scl_level_o, sda_level_o}, 24'h00_0009);
    start_i <= 0;
    end_sim();
  end
endmodule
